//--- design/dmcb_pkg.sv
// Shared constants and types for the channel B transfer control block.
package dmcb_pkg;

    // Bus and datapath widths.
    localparam int PADDR_W = 24;
    localparam int ADDR_W = 24;
    localparam int COUNT_W = 16;

    // Register indices; the byte address is four times the index.
    localparam logic [21:0] IDX_PERIPH_ADDR = 22'h0fff2e;
    localparam logic [21:0] IDX_CTRL = 22'h0fff2f;
    localparam logic [21:0] IDX_COUNT = 22'h0fff2c;
    localparam logic [21:0] IDX_MEM_ADDR = 22'h0fff28;
    localparam logic [21:0] IDX_CONFIG = 22'h0fff30;
    localparam logic [21:0] IDX_STATUS = 22'h0fff31;

    // Control register fields.
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_DIR_BIT = 5;
    localparam int CTRL_STEP_EN_BIT = 4;
    localparam int CTRL_MODE_SEL_BIT = 3;
    localparam int CTRL_SEL_MSB = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Configuration register fields.
    localparam int CFG_SIZE_BIT = 0;
    localparam int CFG_BLOCK_BIT = 1;
    localparam logic [1:0] CFG_RESET = 2'h0;

    // Reset values of the remaining registers.
    localparam logic [7:0] PERIPH_ADDR_RESET = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] MEM_ADDR_RESET = 24'h000000;

    // Address steps for byte and word transfers.
    localparam logic [ADDR_W-1:0] STEP_BYTE = 24'h000001;
    localparam logic [ADDR_W-1:0] STEP_WORD = 24'h000002;

    // Activation source codes.
    typedef enum logic [2:0]
    {
        ACT_TMR0 = 3'b000,
        ACT_TMR1 = 3'b001,
        ACT_TMR2 = 3'b010,
        ACT_ADC = 3'b011,
        ACT_NONE4 = 3'b100,
        ACT_NONE5 = 3'b101,
        ACT_EXT_EDGE = 3'b110,
        ACT_EXT_LOW = 3'b111
    } dmcb_act_t;

    // Channel sequencer states.
    typedef enum logic [0:0]
    {
        ST_IDLE = 1'b0,
        ST_REQ = 1'b1
    } dmcb_state_t;

endpackage : dmcb_pkg

//--- design/dmcb_trig_sel.sv
// Activation source selection and external request edge detection.
`timescale 1ns/1ns
module dmcb_trig_sel
    import dmcb_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic block_in,
    input wire dmcb_pkg::dmcb_act_t sel_in,
    input wire logic tmr0_in,
    input wire logic tmr1_in,
    input wire logic tmr2_in,
    input wire logic adc_end_in,
    input wire logic ext_req_n_in,
    output logic evt_out,
    output logic lvl_out,
    output logic auto_out,
    output logic burst_out
);

    logic evt_nxt;
    logic ext_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // Only the source named by the code and the mode may raise a request; all
    // other sources are dropped here, so nothing downstream can see them.
    always_comb
    begin
        evt_nxt = 1'b0;
        lvl_out = 1'b0;
        auto_out = 1'b0;
        burst_out = 1'b0;
        case (sel_in)
            ACT_TMR0:
            begin
                auto_out = block_in; // R02
                burst_out = block_in; // R02
                evt_nxt = !block_in && tmr0_in; // R02
            end
            ACT_TMR1: evt_nxt = !block_in && tmr1_in; // R03
            ACT_TMR2:
            begin
                auto_out = block_in; // R04
                evt_nxt = !block_in && tmr2_in; // R04
            end
            ACT_ADC: evt_nxt = !block_in && adc_end_in; // R05
            ACT_EXT_EDGE: evt_nxt = ext_prev_r && !ext_req_n_in; // R07
            ACT_EXT_LOW: lvl_out = !block_in && !ext_req_n_in; // R08
            default: evt_nxt = 1'b0; // R06
        endcase
        lvl_out = lvl_out || auto_out;
        if (!enable_in)
        begin
            evt_nxt = 1'b0; // R01
            lvl_out = 1'b0; // R01
        end
    end

    // The previous pin level starts high, so a pin already low at reset counts as a falling edge.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ext_prev_r <= 1'b1;
            evt_out <= 1'b0;
        end
        else
        begin
            ext_prev_r <= ext_req_n_in;
            evt_out <= evt_nxt; // R12
        end
    end

endmodule : dmcb_trig_sel

//--- design/dmcb_addr_step.sv
// Memory address register B with its per-transfer step logic.
`timescale 1ns/1ns
module dmcb_addr_step
    import dmcb_pkg::*;
#(
    parameter int AW = dmcb_pkg::ADDR_W
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic load_in,
    input wire logic [AW-1:0] load_data_in,
    input wire logic step_in,
    input wire logic step_en_in,
    input wire logic dir_in,
    input wire logic word_in,
    output logic [AW-1:0] addr_out
);

    logic [AW-1:0] step_amt;

    // A word step needs at least two address bits to mean anything.
    if (AW < 2)
    begin : g_bad_width
        $error("dmcb_addr_step: address width below 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Step size follows the transfer size.
    assign step_amt = word_in ? STEP_WORD[AW-1:0] : STEP_BYTE[AW-1:0]; // R11

    // A software load wins over a step landing in the same cycle.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            addr_out <= MEM_ADDR_RESET[AW-1:0];
        end
        else if (load_in)
        begin
            addr_out <= load_data_in;
        end
        else if (step_in && step_en_in) // R10
        begin
            addr_out <= dir_in ? addr_out - step_amt : addr_out + step_amt; // R11
        end
    end

endmodule : dmcb_addr_step

//--- design/dmcb_chan_ctrl.sv
// Channel B transfer control: registers, activation and transfer sequencing.
//
// What this block does
// R01: No transfer starts while the master enable bit is clear.
// R02: Code 0 takes timer 0 match in normal mode, auto burst in block mode.
// R03: Code 1 takes timer 1 match in normal mode, nothing in block mode.
// R04: Code 2 takes timer 2 match in normal mode, auto cycle-steal in block.
// R05: Code 3 takes converter end in normal mode, nothing in block mode.
// R06: Codes 4 and 5 select no source in either mode.
// R07: Code 6 starts a transfer on a falling edge of the external request.
// R08: Code 7 requests while the external request is low, normal mode only.
// R09: Mode-select bit 0 makes destination the block area, 1 makes source.
// R10: Bit 5 is destination step direction, bit 4 destination step enable.
// R11: Address holds, or rises or falls by 1 or 2 after each transfer.
// R12: Requests from unselected sources are ignored; unavailable codes stay idle.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module dmcb_chan_ctrl
    import dmcb_pkg::*;
(
    input wire logic CLOCK_IN,
    input wire logic ARST_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [dmcb_pkg::PADDR_W-1:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic TMR0_MATCH_IN,
    input wire logic TMR1_MATCH_IN,
    input wire logic TMR2_MATCH_IN,
    input wire logic ADC_END_IN,
    input wire logic EXT_REQ_N_IN,
    input wire logic XFER_DONE_IN,
    output logic XFER_REQ_OUT,
    output logic XFER_WORD_OUT,
    output logic BLOCK_SRC_OUT,
    output logic [7:0] PERIPH_ADDR_OUT,
    output logic [dmcb_pkg::ADDR_W-1:0] MEM_ADDR_OUT
);

    logic rst_meta_r;
    logic rst_n;
    logic [7:0] ctrl_r;
    logic [1:0] cfg_r;
    logic [COUNT_W-1:0] count_r;
    logic pend_r;
    dmcb_state_t state_r;
    dmcb_state_t state_nxt;
    logic [21:0] idx;
    logic setup;
    logic wr_acc;
    logic hit;
    logic [31:0] rdata_nxt;
    logic evt;
    logic lvl;
    logic auto_sel;
    logic burst;
    logic lvl_ok;
    logic done;
    logic ctrl_en;
    logic blk;
    dmcb_act_t sel;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release goes through two flops so every flop leaves reset together.
    always_ff @(posedge CLOCK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode; the address is stable from setup through access.
    assign idx = PADDR_IN[23:2];
    assign setup = PSEL_IN && !PENABLE_IN;
    assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
    assign ctrl_en = ctrl_r[CTRL_EN_BIT];
    assign blk = cfg_r[CFG_BLOCK_BIT];
    assign sel = dmcb_act_t'(ctrl_r[CTRL_SEL_MSB:0]);
    assign done = (state_r == ST_REQ) && XFER_DONE_IN;

    // Read mux; unmapped indices read zero and flag an error.
    always_comb
    begin
        hit = 1'b1;
        rdata_nxt = 32'h00000000;
        case (idx)
            IDX_PERIPH_ADDR: rdata_nxt = {24'h000000, PERIPH_ADDR_OUT};
            IDX_CTRL: rdata_nxt = {24'h000000, ctrl_r};
            IDX_COUNT: rdata_nxt = {16'h0000, count_r};
            IDX_MEM_ADDR: rdata_nxt = {8'h00, MEM_ADDR_OUT};
            IDX_CONFIG: rdata_nxt = {30'h00000000, cfg_r};
            IDX_STATUS: rdata_nxt = {29'h00000000, count_r == '0, pend_r, XFER_REQ_OUT};
            default: hit = 1'b0;
        endcase
    end

    // Zero wait states: ready rises for exactly the access cycle, which keeps
    // every bus output on a flop at the cost of no back-to-back shortcut.
    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            PREADY_OUT <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT <= 32'h00000000;
        end
        else
        begin
            PREADY_OUT <= setup;
            PSLVERR_OUT <= setup && !hit;
            if (setup && !PWRITE_IN)
            begin
                PRDATA_OUT <= rdata_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers.
    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= CTRL_RESET;
            cfg_r <= CFG_RESET;
            PERIPH_ADDR_OUT <= PERIPH_ADDR_RESET;
        end
        else if (wr_acc)
        begin
            if (idx == IDX_CTRL)
            begin
                ctrl_r <= PWDATA_IN[7:0];
            end
            if (idx == IDX_CONFIG)
            begin
                cfg_r <= PWDATA_IN[1:0];
            end
            if (idx == IDX_PERIPH_ADDR)
            begin
                PERIPH_ADDR_OUT <= PWDATA_IN[7:0];
            end
        end
    end

    // The count falls once per finished transfer and holds at zero; a software write wins.
    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r <= COUNT_RESET;
        end
        else if (wr_acc && idx == IDX_COUNT)
        begin
            count_r <= PWDATA_IN[COUNT_W-1:0];
        end
        else if (done && count_r != '0)
        begin
            count_r <= count_r - 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Source selection lives in its own module.
    dmcb_trig_sel u_trig
    (
        .clk_in(CLOCK_IN),
        .rst_n_in(rst_n),
        .enable_in(ctrl_en),
        .block_in(blk),
        .sel_in(sel),
        .tmr0_in(TMR0_MATCH_IN),
        .tmr1_in(TMR1_MATCH_IN),
        .tmr2_in(TMR2_MATCH_IN),
        .adc_end_in(ADC_END_IN),
        .ext_req_n_in(EXT_REQ_N_IN),
        .evt_out(evt),
        .lvl_out(lvl),
        .auto_out(auto_sel),
        .burst_out(burst)
    );

    // Auto-request stops when the block counter runs out.
    assign lvl_ok = lvl && (!auto_sel || count_r != '0);

    // An event landing while one waits is kept; set wins over the clear.
    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_r <= 1'b0;
        end
        else if (evt)
        begin
            pend_r <= 1'b1; // R12
        end
        else if (state_r == ST_IDLE && state_nxt == ST_REQ || !ctrl_en)
        begin
            pend_r <= 1'b0; // R01
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer: burst stays in request; cycle-steal drops to idle in between.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (ctrl_en && (pend_r || lvl_ok)) // R01
                begin
                    state_nxt = ST_REQ;
                end
            end
            ST_REQ:
            begin
                if (XFER_DONE_IN)
                begin
                    state_nxt = (burst && ctrl_en && count_r > 16'h0001) ? ST_REQ : ST_IDLE; // R02
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK_IN or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= ST_IDLE;
            XFER_REQ_OUT <= 1'b0;
            XFER_WORD_OUT <= 1'b0;
            BLOCK_SRC_OUT <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            XFER_REQ_OUT <= state_nxt == ST_REQ;
            XFER_WORD_OUT <= cfg_r[CFG_SIZE_BIT];
            BLOCK_SRC_OUT <= blk && ctrl_r[CTRL_MODE_SEL_BIT]; // R09
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Destination address stepping.
    dmcb_addr_step #(.AW(ADDR_W)) u_addr
    (
        .clk_in(CLOCK_IN),
        .rst_n_in(rst_n),
        .load_in(wr_acc && idx == IDX_MEM_ADDR),
        .load_data_in(PWDATA_IN[ADDR_W-1:0]),
        .step_in(done),
        .step_en_in(ctrl_r[CTRL_STEP_EN_BIT]), // R10
        .dir_in(ctrl_r[CTRL_DIR_BIT]), // R10
        .word_in(cfg_r[CFG_SIZE_BIT]),
        .addr_out(MEM_ADDR_OUT)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!rst_n);

    a_disabled_no_start: assert property ( // R01
        (state_r == ST_IDLE && !ctrl_en) |=> !XFER_REQ_OUT)
        else $error("transfer started while disabled");

    a_tmr0_starts: assert property ( // R02
        (ctrl_en && !blk && sel == ACT_TMR0 && TMR0_MATCH_IN && state_r == ST_IDLE)
        ##1 (ctrl_en && state_r == ST_IDLE)[*2] |=> XFER_REQ_OUT)
        else $error("timer 0 match did not start a transfer");

    a_code1_block_idle: assert property ( // R03
        (blk && sel == ACT_TMR1) |-> !lvl ##1 !evt)
        else $error("code 1 produced a request in block mode");

    a_steal_gap: assert property ( // R04
        (blk && sel == ACT_TMR2 && done) |=> !XFER_REQ_OUT)
        else $error("cycle-steal transfer did not release the request");

    a_adc_starts: assert property ( // R05
        (ctrl_en && !blk && sel == ACT_ADC && ADC_END_IN && state_r == ST_IDLE)
        ##1 (ctrl_en && state_r == ST_IDLE)[*2] |=> XFER_REQ_OUT)
        else $error("converter end did not start a transfer");

    a_dead_codes: assert property ( // R06
        (sel == ACT_NONE4 || sel == ACT_NONE5) |-> !lvl ##1 !evt)
        else $error("unavailable code produced a request");

    a_ext_edge: assert property ( // R07
        (ctrl_en && sel == ACT_EXT_EDGE && $fell(EXT_REQ_N_IN)) |=> evt)
        else $error("falling edge of external request missed");

    a_ext_low_block: assert property ( // R08
        (blk && sel == ACT_EXT_LOW) |-> !lvl)
        else $error("low-level request accepted in block mode");

    a_block_area: assert property ( // R09
        (blk && ctrl_r[CTRL_MODE_SEL_BIT])[*2] |-> BLOCK_SRC_OUT)
        else $error("block area side not reported");

    a_addr_hold: assert property ( // R10
        (done && !ctrl_r[CTRL_STEP_EN_BIT] && !wr_acc) |=> $stable(MEM_ADDR_OUT))
        else $error("address moved with stepping disabled");

    a_addr_inc_word: assert property ( // R11
        (done && ctrl_r[CTRL_STEP_EN_BIT] && !ctrl_r[CTRL_DIR_BIT] && cfg_r[CFG_SIZE_BIT]
         && !wr_acc) |=> MEM_ADDR_OUT == $past(MEM_ADDR_OUT) + 24'h000002)
        else $error("word increment wrong");

    a_quiet_idle: assert property ( // R12
        (state_r == ST_IDLE && !pend_r && !lvl_ok) |=> !XFER_REQ_OUT)
        else $error("request without a selected source");

endmodule : dmcb_chan_ctrl

//--- sim/dmcb_engine_model.sv
// Behavioural transfer engine that answers channel B transfer requests.
`timescale 1ns/1ns
module dmcb_engine_model
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic req_in,
    input wire logic slow_in,
    output logic done_out,
    output logic [7:0] n_done_out
);
    logic [3:0] wait_r;

    ////////////////////////////////////////////////////////////////////////
    // One done pulse per request; the slow setting stretches each transfer.
    // The wait restarts after every pulse so a burst gets one pulse a unit.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            done_out <= 1'b0;
            wait_r <= 4'h0;
            n_done_out <= 8'h00;
        end
        else if (done_out)
        begin
            done_out <= 1'b0;
            wait_r <= 4'h0;
        end
        else if (req_in && wait_r >= (slow_in ? 4'h5 : 4'h0))
        begin
            done_out <= 1'b1;
            n_done_out <= n_done_out + 8'h01;
        end
        else if (req_in)
        begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule : dmcb_engine_model

//--- sim/tb.sv
// Self-checking bench for the channel B transfer control block.
`timescale 1ns/1ns
module tb;
    import dmcb_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic req, word, bsrc, done, slow;
    logic [23:0] paddr, maddr;
    logic [31:0] pwdata, prdata, rd, got, want;
    logic [4:0] src;
    logic [7:0] paout, nd, base;
    logic [21:0] idx_l [5];
    logic [7:0] cfg_l [5], cnt_l [5], ctl_l [5];
    logic [23:0] adr_l [5];
    int n_mismatch, checks;

    dmcb_chan_ctrl i_dut (.CLOCK_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .TMR0_MATCH_IN(src[0]), .TMR1_MATCH_IN(src[1]),
        .TMR2_MATCH_IN(src[2]), .ADC_END_IN(src[3]), .EXT_REQ_N_IN(!src[4]),
        .XFER_DONE_IN(done), .XFER_REQ_OUT(req), .XFER_WORD_OUT(word),
        .BLOCK_SRC_OUT(bsrc), .PERIPH_ADDR_OUT(paout), .MEM_ADDR_OUT(maddr));

    dmcb_engine_model i_eng (.clk_in(clk), .rst_n_in(rst_n), .req_in(req),
        .slow_in(slow), .done_out(done), .n_done_out(nd));

    ////////////////////////////////////////////////////////////////////////
    // Clock, and a watchdog that ends a hung run through the same verdict.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial
    begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        conclude();
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; the request holds until pready is sampled high or 20 more cycles pass.
    task automatic apb(input logic w, input logic [21:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 20)
            chk("pready", 32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input int s);
        @(posedge clk);
        src[s] <= 1'b1;
        @(posedge clk);
        src <= 5'h00;
    endtask : pulse

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, activation table, block mode, stepping.
    initial
    begin
        rst_n = 1'b0;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 24'h000000;
        pwdata = 32'h00000000;
        src = 5'h00;
        idx_l = '{IDX_PERIPH_ADDR, IDX_CTRL, IDX_COUNT, IDX_MEM_ADDR, IDX_CONFIG};
        cfg_l = '{8'h02, 8'h03, 8'h02, 8'h00, 8'h03};
        cnt_l = '{8'h03, 8'h02, 8'h02, 8'h00, 8'h02};
        ctl_l = '{8'h92, 8'hb8, 8'ha2, 8'h08, 8'h92};
        adr_l = '{24'h000103, 24'h0000fc, 24'h000100, 24'h000100, 24'h000104};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (idx_l[i])
        begin
            apb(1'b0, idx_l[i], 32'h0);
            chk("reset value", rd, 32'h0);
        end
        apb(1'b0, 22'h0fff20, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b1, IDX_PERIPH_ADDR, 32'h000000a5);
        apb(1'b0, IDX_PERIPH_ADDR, 32'h0);
        chk("periph read", rd, 32'h000000a5);
        chk("periph port", {24'h0, paout}, 32'h000000a5);
        apb(1'b1, IDX_CTRL, 32'h0000003f);
        apb(1'b0, IDX_CTRL, 32'h0);
        chk("ctrl read", rd, 32'h0000003f);
        // Normal mode: each source alone, with the master enable off and on.
        for (int en = 0; en < 2; en++)
            for (int c = 0; c < 8; c++)
                for (int s = 0; s < 5; s++)
                begin
                    apb(1'b1, IDX_CTRL, {24'h0, en[0], 4'h0, c[2:0]});
                    base = nd;
                    pulse(s);
                    repeat (30) @(posedge clk);
                    got = {24'h0, nd - base};
                    want = {31'h0, en == 1 && ((c < 4 && s == c) || (c > 5 && s == 4))};
                    chk("normal dones", got, want);
                end
        // Block mode: auto codes run one unit, only the edge code takes a pulse.
        apb(1'b1, IDX_CONFIG, 32'h2);
        slow <= 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, IDX_CTRL, 32'h0);
            apb(1'b1, IDX_COUNT, 32'h1);
            base = nd;
            apb(1'b1, IDX_CTRL, {24'h0, 5'h10, c[2:0]});
            for (int s = 0; s < 5; s++)
                pulse(s);
            repeat (60) @(posedge clk);
            got = {24'h0, nd - base};
            want = {31'h0, c == 0 || c == 2 || c == 6};
            chk("block dones", got, want);
        end
        // Address stepping and block area side, from a table of settings.
        foreach (cfg_l[i])
        begin
            apb(1'b1, IDX_CTRL, 32'h0);
            apb(1'b1, IDX_CONFIG, {24'h0, cfg_l[i]});
            apb(1'b1, IDX_COUNT, {24'h0, cnt_l[i]});
            apb(1'b1, IDX_MEM_ADDR, 32'h00000100);
            slow <= i[0];
            apb(1'b1, IDX_CTRL, {24'h0, ctl_l[i]});
            repeat (80) @(posedge clk);
            chk("mem addr port", {8'h0, maddr}, {8'h0, adr_l[i]});
            apb(1'b0, IDX_MEM_ADDR, 32'h0);
            chk("mem addr read", rd, {8'h0, adr_l[i]});
            apb(1'b0, IDX_COUNT, 32'h0);
            chk("count read", rd, 32'h0);
            apb(1'b0, IDX_STATUS, 32'h0);
            chk("status read", rd, 32'h4);
            chk("block source", {31'h0, bsrc}, {31'h0, i == 1});
            chk("word size", {31'h0, word}, {31'h0, cfg_l[i][0]});
            chk("request idle", {31'h0, req}, 32'h0);
        end
        conclude();
    end
endmodule : tb
